// ### rtl/tis_pkg.sv
// Package: register map, field positions and carrier types of the timer input select block
package tis_pkg;

   // Register map (byte address within the block)
   localparam logic [15:0] TIS_OPT_OFFSET = 16'h100c;
   localparam int TIS_ADDR_W = 16;

   // Field positions
   localparam int TIS_T2_CLK_BIT = 26;
   localparam int TIS_T1_CLK_BIT = 25;
   localparam int TIS_T0_CLK_BIT = 24;
   localparam int TIS_T2_CAP_BIT = 20;
   localparam int TIS_T1_CAP_BIT = 18;

   // Writable bits and reset value
   localparam logic [31:0] TIS_OPT_WMASK = 32'h0714_0000;
   localparam logic [31:0] TIS_OPT_RESET = 32'h0000_0000;

   // Clock pin choice and capture source choice
   typedef enum logic {
      TIS_CLK_PIN_A = 1'b0,
      TIS_CLK_PIN_B = 1'b1
   } tis_clk_pin_t;

   typedef enum logic {
      TIS_CAP_PIN = 1'b0,
      TIS_CAP_CMP = 1'b1
   } tis_cap_src_t;

   // Raw signals offered to the timers
   typedef struct packed {
      logic timer_ext_clock_input_a;
      logic timer_ext_clock_input_b;
      logic analog_comparator0_output;
      logic timer1_channel0_pin_signal;
      logic timer2_channel0_pin_signal;
   } tis_src_t;

   // Routed signals that feed the timers
   typedef struct packed {
      logic timer0_ext_clock;
      logic timer1_ext_clock;
      logic timer2_ext_clock;
      logic timer1_ch0_capture_in;
      logic timer2_ch0_capture_in;
   } tis_route_t;

endpackage : tis_pkg

// ### rtl/tis_sel2.sv
// Module: registered two-way selector for one routed timer input
`timescale 1ns/10ps
module tis_sel2 (
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // Select and sources
   input wire logic sel,
   input wire logic in0,
   input wire logic in1,
   // Routed output
   output logic out_q
);
   logic out_d;

   always_comb begin
      out_d = sel ? in1 : in0;
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         out_q <= 1'b0;
      end else begin
         out_q <= out_d;
      end
   end
endmodule : tis_sel2

// ### rtl/tis_top.sv
// Module: timer input select option register with APB slave and signal routing
// Notes on behaviour
// - Bit 26 picks timer 2 clock pin
// - Bit 25 picks timer 1 clock pin
// - Bit 24 picks timer 0 clock pin
// - Bit 20 picks timer 2 capture source
// - Bit 18 picks timer 1 capture source
// - Reserved bits read zero, not writable
//
// Chosen here: register access over APB.
`timescale 1ns/10ps
module tis_top
   import tis_pkg::*;
(
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [TIS_ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Raw sources
   input wire tis_src_t src,
   // Static selects
   output logic timer2_ext_clock_pin_select,
   output logic timer1_ext_clock_pin_select,
   output logic timer0_ext_clock_pin_select,
   output logic timer2_ch0_capture_source,
   output logic timer1_ch0_capture_source,
   // Routed timer inputs
   output tis_route_t route
);

   ////////////////////////////////////////////////////////////////////////////
   // Option register
   logic [31:0] opt_q;
   logic [31:0] opt_d;
   logic [31:0] prdata_d;
   logic pslverr_d;
   logic hit;
   logic setup;
   logic [31:0] bmask;
   logic wr_en;

   assign setup = psel && !penable;
   assign hit = (paddr == TIS_OPT_OFFSET);
   // Write lands at the edge that ends the access phase
   assign wr_en = psel && penable && pready && pwrite && hit;

   always_comb begin
      bmask = {{8{pstrb[3]}}, {8{pstrb[2]}}, {8{pstrb[1]}}, {8{pstrb[0]}}};
      opt_d = opt_q;
      if (wr_en) begin
         // Only select bits take writes
         opt_d = (opt_q & ~(TIS_OPT_WMASK & bmask))
               | (pwdata & TIS_OPT_WMASK & bmask);
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         opt_q <= TIS_OPT_RESET;
      end else begin
         opt_q <= opt_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // APB answer: no wait state, read data registered
   logic pready_d;

   always_comb begin
      pready_d = setup;
      prdata_d = 32'h0000_0000;
      pslverr_d = 1'b0;
      if (setup) begin
         if (hit && !pwrite) begin
            prdata_d = opt_q & TIS_OPT_WMASK;
         end
         pslverr_d = !hit;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready <= 1'b0;
         prdata <= 32'h0000_0000;
         pslverr <= 1'b0;
      end else begin
         pready <= pready_d;
         prdata <= prdata_d;
         pslverr <= pslverr_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Select outputs
   logic t2_clk_sel_d;
   logic t1_clk_sel_d;
   logic t0_clk_sel_d;
   logic t2_cap_src_d;
   logic t1_cap_src_d;

   always_comb begin
      t2_clk_sel_d = opt_q[TIS_T2_CLK_BIT];
      t1_clk_sel_d = opt_q[TIS_T1_CLK_BIT];
      t0_clk_sel_d = opt_q[TIS_T0_CLK_BIT];
      t2_cap_src_d = opt_q[TIS_T2_CAP_BIT];
      t1_cap_src_d = opt_q[TIS_T1_CAP_BIT];
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         timer2_ext_clock_pin_select <= 1'b0;
         timer1_ext_clock_pin_select <= 1'b0;
         timer0_ext_clock_pin_select <= 1'b0;
         timer2_ch0_capture_source <= 1'b0;
         timer1_ch0_capture_source <= 1'b0;
      end else begin
         timer2_ext_clock_pin_select <= t2_clk_sel_d;
         timer1_ext_clock_pin_select <= t1_clk_sel_d;
         timer0_ext_clock_pin_select <= t0_clk_sel_d;
         timer2_ch0_capture_source <= t2_cap_src_d;
         timer1_ch0_capture_source <= t1_cap_src_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Routing of timer inputs
   logic t0_clk_q;
   logic t1_clk_q;
   logic t2_clk_q;
   logic t1_cap_q;
   logic t2_cap_q;

   tis_sel2 u_t2_clk (
      .pclk(pclk),
      .presetn(presetn),
      .sel(opt_q[TIS_T2_CLK_BIT]),
      .in0(src.timer_ext_clock_input_a),
      .in1(src.timer_ext_clock_input_b),
      .out_q(t2_clk_q)
   );
   tis_sel2 u_t1_clk (
      .pclk(pclk),
      .presetn(presetn),
      .sel(opt_q[TIS_T1_CLK_BIT]),
      .in0(src.timer_ext_clock_input_a),
      .in1(src.timer_ext_clock_input_b),
      .out_q(t1_clk_q)
   );
   tis_sel2 u_t0_clk (
      .pclk(pclk),
      .presetn(presetn),
      .sel(opt_q[TIS_T0_CLK_BIT]),
      .in0(src.timer_ext_clock_input_a),
      .in1(src.timer_ext_clock_input_b),
      .out_q(t0_clk_q)
   );
   tis_sel2 u_t2_cap (
      .pclk(pclk),
      .presetn(presetn),
      .sel(opt_q[TIS_T2_CAP_BIT]),
      .in0(src.timer2_channel0_pin_signal),
      .in1(src.analog_comparator0_output),
      .out_q(t2_cap_q)
   );
   tis_sel2 u_t1_cap (
      .pclk(pclk),
      .presetn(presetn),
      .sel(opt_q[TIS_T1_CAP_BIT]),
      .in0(src.timer1_channel0_pin_signal),
      .in1(src.analog_comparator0_output),
      .out_q(t1_cap_q)
   );

   // One driver for the whole carrier
   assign route = '{
      timer0_ext_clock: t0_clk_q,
      timer1_ext_clock: t1_clk_q,
      timer2_ext_clock: t2_clk_q,
      timer1_ch0_capture_in: t1_cap_q,
      timer2_ch0_capture_in: t2_cap_q
   };

endmodule : tis_top

// ### sim/tis_top_sva.sv
// Timer select checker
`timescale 1ns/10ps
module tis_top_sva
   import tis_pkg::*;
(
   // Bus
   input logic pclk,
   input logic presetn,
   input logic penable,
   input logic pwrite,
   input logic [15:0] paddr,
   input logic [31:0] pwdata,
   input logic [3:0] pstrb,
   input logic [31:0] prdata,
   input logic pready,
   // Selects
   input logic timer2_ext_clock_pin_select,
   input logic timer1_ext_clock_pin_select,
   input logic timer0_ext_clock_pin_select,
   input logic timer2_ch0_capture_source,
   input logic timer1_ch0_capture_source
);
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   logic v;
   logic w;
   assign v = penable && pready && pwrite && paddr == TIS_OPT_OFFSET;
   assign w = v && pstrb == 4'hf;
   a_t2_clk: assert property (w |-> ##2
      timer2_ext_clock_pin_select == $past(pwdata[26], 2)) else $error("t2");
   a_t1_clk: assert property (w |-> ##2
      timer1_ext_clock_pin_select == $past(pwdata[25], 2)) else $error("t1");
   a_t0_clk: assert property (w |-> ##2
      timer0_ext_clock_pin_select == $past(pwdata[24], 2)) else $error("t0");
   a_t2_cap: assert property (w |-> ##2
      timer2_ch0_capture_source == $past(pwdata[20], 2)) else $error("c2");
   a_t1_cap: assert property (w |-> ##2
      timer1_ch0_capture_source == $past(pwdata[18], 2)) else $error("c1");
   a_rsvd_zero: assert property (pready && !pwrite |->
      (prdata & ~TIS_OPT_WMASK) == 0) else $error("rsvd");
   a_sel_hold: assert property (!v && !$past(v) |=>
      $stable(timer0_ext_clock_pin_select)) else $error("hold");
   c_wr: cover property (w);
   c_rd: cover property (pready && !pwrite);
   c_cap: cover property (timer1_ch0_capture_source);
   c_lane: cover property (v && pstrb == 4'h4);
endmodule : tis_top_sva

// ### sim/tis_top_tb_top.sv
// Timer select tests
`timescale 1ns/10ps
module tis_top_tb_top;
   import tis_pkg::*;
   logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr;
   logic timer2_ext_clock_pin_select, timer1_ext_clock_pin_select;
   logic timer0_ext_clock_pin_select, timer2_ch0_capture_source;
   logic timer1_ch0_capture_source;
   logic [15:0] paddr = 0;
   logic [31:0] pwdata = 0, prdata;
   logic [3:0] pstrb = 0;
   tis_src_t src = '0;
   tis_route_t route;
   int miscompares = 0, compares = 0;
   tis_top dut (
      .pclk(pclk),
      .presetn(presetn),
      .psel(psel),
      .penable(penable),
      .pwrite(pwrite),
      .paddr(paddr),
      .pwdata(pwdata),
      .pstrb(pstrb),
      .prdata(prdata),
      .pready(pready),
      .pslverr(pslverr),
      .src(src),
      .timer2_ext_clock_pin_select(timer2_ext_clock_pin_select),
      .timer1_ext_clock_pin_select(timer1_ext_clock_pin_select),
      .timer0_ext_clock_pin_select(timer0_ext_clock_pin_select),
      .timer2_ch0_capture_source(timer2_ch0_capture_source),
      .timer1_ch0_capture_source(timer1_ch0_capture_source),
      .route(route)
   );
   initial begin
      forever #50 pclk = ~pclk;
   end
   task automatic chk(string n, logic [31:0] x, logic [31:0] g);
      compares++;
      if (g !== x) begin
         miscompares++;
         $display("[FAIL] %s exp %h got %h", n, x, g);
      end
   endtask : chk
   // Setup, then access held until pready is seen high at an edge
   task automatic apb(input logic w, input logic [15:0] a, input logic [31:0] d,
         input logic [3:0] s, output logic [31:0] r, output logic e);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      pstrb <= s;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
      end while (pready !== 1'b1);
      r = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   task automatic t_bits;
      int p[5] = '{24, 25, 26, 18, 20};
      logic [31:0] rd;
      logic er;
      src <= 5'h13;
      apb(1'b0, TIS_OPT_OFFSET, 32'h0000_0000, 4'h0, rd, er);
      chk("rst", 32'h0000_0000, rd);
      for (int b = 0; b < 5; b++) begin
         apb(1'b1, TIS_OPT_OFFSET, 32'h0000_0001 << p[b], 4'hf, rd, er);
         chk("wr_err", 32'h0000_0000, er);
         apb(1'b0, TIS_OPT_OFFSET, 32'h0000_0000, 4'h0, rd, er);
         chk("rd", 32'h0000_0001 << p[b], rd);
         chk("rt", 5'h1f ^ (5'h10 >> b), route);
         chk("sel", 5'h10 >> b, {timer0_ext_clock_pin_select,
            timer1_ext_clock_pin_select, timer2_ext_clock_pin_select,
            timer1_ch0_capture_source, timer2_ch0_capture_source});
      end
      src <= 5'h0c;
      repeat (2) @(posedge pclk);
      chk("rt_src", 32'h0000_0001, route);
      $display("bits done");
   endtask : t_bits
   task automatic t_lanes;
      logic [31:0] rd;
      logic er;
      apb(1'b1, TIS_OPT_OFFSET, 32'hffff_ffff, 4'h4, rd, er);
      apb(1'b0, TIS_OPT_OFFSET, 32'h0000_0000, 4'h0, rd, er);
      chk("l2", 32'h0014_0000, rd);
      apb(1'b1, 16'h1008, 32'hffff_ffff, 4'hf, rd, er);
      chk("un_wr_err", 32'h0000_0001, er);
      apb(1'b0, 16'h1008, 32'h0000_0000, 4'h0, rd, er);
      chk("un", 32'h0000_0000, rd);
      chk("un_rd_err", 32'h0000_0001, er);
      apb(1'b0, TIS_OPT_OFFSET, 32'h0000_0000, 4'h0, rd, er);
      chk("kept", 32'h0014_0000, rd);
      chk("ok_err", 32'h0000_0000, er);
      apb(1'b1, TIS_OPT_OFFSET, 32'hffff_ffff, 4'h8, rd, er);
      apb(1'b0, TIS_OPT_OFFSET, 32'h0000_0000, 4'h0, rd, er);
      chk("l3", 32'h0714_0000, rd);
      $display("lanes done");
   endtask : t_lanes
   task automatic t_reset;
      logic [31:0] rd;
      logic er;
      apb(1'b1, TIS_OPT_OFFSET, 32'hffff_ffff, 4'hf, rd, er);
      apb(1'b0, TIS_OPT_OFFSET, 32'h0000_0000, 4'h0, rd, er);
      chk("all", 32'h0714_0000, rd);
      @(posedge pclk);
      presetn <= 1'b0;
      repeat (3) @(posedge pclk);
      chk("rst_sel", 32'h0000_0000, {timer0_ext_clock_pin_select,
         timer1_ext_clock_pin_select, timer2_ext_clock_pin_select,
         timer1_ch0_capture_source, timer2_ch0_capture_source});
      chk("rst_rt", 32'h0000_0000, route);
      presetn <= 1'b1;
      apb(1'b0, TIS_OPT_OFFSET, 32'h0000_0000, 4'h0, rd, er);
      chk("rst_rd", 32'h0000_0000, rd);
      $display("reset done");
   endtask : t_reset
   task automatic wrap_up;
      $display("%0d compares %0d miscompares", compares, miscompares);
      if (miscompares == 0 && compares > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask : wrap_up
   initial begin
      repeat (6) @(posedge pclk);
      presetn <= 1'b1;
      t_bits;
      t_lanes;
      t_reset;
      wrap_up;
   end
   // About 100 cycles of tests; give up after 2000
   initial begin
      #200000;
      miscompares++;
      wrap_up;
   end
endmodule : tis_top_tb_top
bind tis_top tis_top_sva u_sva (
   .pclk(pclk),
   .presetn(presetn),
   .penable(penable),
   .pwrite(pwrite),
   .paddr(paddr),
   .pwdata(pwdata),
   .pstrb(pstrb),
   .prdata(prdata),
   .pready(pready),
   .timer2_ext_clock_pin_select(timer2_ext_clock_pin_select),
   .timer1_ext_clock_pin_select(timer1_ext_clock_pin_select),
   .timer0_ext_clock_pin_select(timer0_ext_clock_pin_select),
   .timer2_ch0_capture_source(timer2_ch0_capture_source),
   .timer1_ch0_capture_source(timer1_ch0_capture_source)
);
